// ---- verilog/port_a_regs.vh ----
`ifndef PORT_A_REGS_VH
`define PORT_A_REGS_VH

// ----------------------------------------
// register map
// ----------------------------------------
`define PORT_OUTPUT_LATCH_ADDR 8'haa
`define PORT_PIN_LEVEL_ADDR 8'hab
`define PORT_DIRECTION_ADDR 8'hac

// ----------------------------------------
// reset values
// ----------------------------------------
`define PORT_OUTPUT_LATCH_RESET 8'h00
`define PORT_DIRECTION_RESET 8'h00
`define PORT_UNMAPPED_READ 8'h00

`endif

// ---- verilog/port_pin_cell.v ----
`timescale 1ns/1ps

// one port pin: output driver and input pull-up steering
module port_pin_cell (
    // control
    input wire latch_bit_in,
    input wire dir_bit_in,
    // pad
    output wire pin_out,
    output wire pin_oe_out,
    output wire pullup_en_out
);

    // 1 selects output, 0 selects input
    assign pin_oe_out = dir_bit_in;
    assign pin_out = latch_bit_in;
    // pull-up only while the pin is an input; 0 leaves it off
    assign pullup_en_out = ~dir_bit_in & latch_bit_in;

endmodule

// ---- verilog/port_a_data.v ----
// Operation
// - the pin level register is read only and returns the present level of each of pins 7 to 0.
// - the output latch sits at address aa and all eight bits are readable and writable.
// - reset clears every bit of the output latch.
// - a pin set as output is driven to its output latch bit, low for 0 and high for 1.
// - a pin set as input with latch bit 0 has its pull-up switched off.
// - a pin set as input with latch bit 1 has its pull-up switched on.
// - the direction register bit selects input with 0 and output with 1.
`timescale 1ns/1ps
`include "port_a_regs.vh"

module port_a_data (
    // clock and reset
    input wire sys_clk_in,
    input wire reset_in,

    // register port
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [7:0] rdata_out,

    // port pins
    input wire [7:0] pin_in,
    output wire [7:0] pin_out,
    output wire [7:0] pin_oe_out,
    output wire [7:0] pullup_en_out
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    reg [7:0] port_output_latch_r;
    reg [7:0] port_output_latch_nxt;
    reg [7:0] port_direction_r;
    reg [7:0] port_direction_nxt;
    reg [7:0] rdata_nxt;

    reg sel_latch;
    reg sel_level;
    reg sel_dir;

    wire latch_we;
    wire dir_we;
    wire [7:0] cell_drive;
    wire [7:0] cell_oe;
    wire [7:0] cell_pullup;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    // exact match only: a partial decode would alias the latch and let stray writes in
    always @* begin
        sel_latch = 1'b0;
        sel_level = 1'b0;
        sel_dir = 1'b0;
        if (addr_in == `PORT_OUTPUT_LATCH_ADDR) begin
            sel_latch = 1'b1;
        end else if (addr_in == `PORT_PIN_LEVEL_ADDR) begin
            sel_level = 1'b1;
        end else if (addr_in == `PORT_DIRECTION_ADDR) begin
            sel_dir = 1'b1;
        end
    end

    // ----------------------------------------
    // write strobes
    // ----------------------------------------
    // the pin level register gets no strobe, so writes to it are dropped
    assign latch_we = wr_in & sel_latch;
    assign dir_we = wr_in & sel_dir;

    // ----------------------------------------
    // next register values
    // ----------------------------------------
    always @* begin
        port_output_latch_nxt = port_output_latch_r;
        if (latch_we) begin
            port_output_latch_nxt = wdata_in;
        end
    end

    always @* begin
        port_direction_nxt = port_direction_r;
        if (dir_we) begin
            port_direction_nxt = wdata_in;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            port_output_latch_r <= `PORT_OUTPUT_LATCH_RESET;
        end else begin
            port_output_latch_r <= port_output_latch_nxt;
        end
    end

    // all inputs after reset, so no pin is driven before software picks a direction
    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            port_direction_r <= `PORT_DIRECTION_RESET;
        end else begin
            port_direction_r <= port_direction_nxt;
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // pin level is sampled live, no synchroniser: inputs are taken as synchronous
    // read data stand one cycle, then fall back to zero so no stale value lingers
    always @* begin
        rdata_nxt = `PORT_UNMAPPED_READ;
        if (rd_in) begin
            if (sel_latch) begin
                rdata_nxt = port_output_latch_r;
            end else if (sel_level) begin
                rdata_nxt = pin_in;
            end else if (sel_dir) begin
                rdata_nxt = port_direction_r;
            end else begin
                rdata_nxt = `PORT_UNMAPPED_READ;
            end
        end
    end

    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            rdata_out <= `PORT_UNMAPPED_READ;
        end else begin
            rdata_out <= rdata_nxt;
        end
    end

    // ----------------------------------------
    // pin cells
    // ----------------------------------------
    // one cell per pin keeps drive and pull-up steering identical on all eight
    // pin 0
    port_pin_cell u_cell_0 (
        .latch_bit_in(port_output_latch_r[0]),
        .dir_bit_in(port_direction_r[0]),
        .pin_out(cell_drive[0]),
        .pin_oe_out(cell_oe[0]),
        .pullup_en_out(cell_pullup[0])
    );

    // pin 1
    port_pin_cell u_cell_1 (
        .latch_bit_in(port_output_latch_r[1]),
        .dir_bit_in(port_direction_r[1]),
        .pin_out(cell_drive[1]),
        .pin_oe_out(cell_oe[1]),
        .pullup_en_out(cell_pullup[1])
    );

    // pin 2
    port_pin_cell u_cell_2 (
        .latch_bit_in(port_output_latch_r[2]),
        .dir_bit_in(port_direction_r[2]),
        .pin_out(cell_drive[2]),
        .pin_oe_out(cell_oe[2]),
        .pullup_en_out(cell_pullup[2])
    );

    // pin 3
    port_pin_cell u_cell_3 (
        .latch_bit_in(port_output_latch_r[3]),
        .dir_bit_in(port_direction_r[3]),
        .pin_out(cell_drive[3]),
        .pin_oe_out(cell_oe[3]),
        .pullup_en_out(cell_pullup[3])
    );

    // pin 4
    port_pin_cell u_cell_4 (
        .latch_bit_in(port_output_latch_r[4]),
        .dir_bit_in(port_direction_r[4]),
        .pin_out(cell_drive[4]),
        .pin_oe_out(cell_oe[4]),
        .pullup_en_out(cell_pullup[4])
    );

    // pin 5
    port_pin_cell u_cell_5 (
        .latch_bit_in(port_output_latch_r[5]),
        .dir_bit_in(port_direction_r[5]),
        .pin_out(cell_drive[5]),
        .pin_oe_out(cell_oe[5]),
        .pullup_en_out(cell_pullup[5])
    );

    // pin 6
    port_pin_cell u_cell_6 (
        .latch_bit_in(port_output_latch_r[6]),
        .dir_bit_in(port_direction_r[6]),
        .pin_out(cell_drive[6]),
        .pin_oe_out(cell_oe[6]),
        .pullup_en_out(cell_pullup[6])
    );

    // pin 7
    port_pin_cell u_cell_7 (
        .latch_bit_in(port_output_latch_r[7]),
        .dir_bit_in(port_direction_r[7]),
        .pin_out(cell_drive[7]),
        .pin_oe_out(cell_oe[7]),
        .pullup_en_out(cell_pullup[7])
    );

    // ----------------------------------------
    // pin outputs
    // ----------------------------------------
    // gathered into the port vectors here so the pad side has one place to look
    assign pin_out = cell_drive;
    assign pin_oe_out = cell_oe;
    assign pullup_en_out = cell_pullup;

endmodule

// ---- tb/port_a_chk.sv ----
`timescale 1ns/1ps

module port_a_chk (
    // clock and reset
    input wire sys_clk_in,
    input wire reset_in,
    // register port
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [7:0] rdata_out,
    // port pins
    input wire [7:0] pin_in,
    input wire [7:0] pin_out,
    input wire [7:0] pin_oe_out,
    input wire [7:0] pullup_en_out
);

    default clocking @(posedge sys_clk_in); endclocking

    // ----------------------------------------
    // bus requests
    // ----------------------------------------
    sequence s_latch_write;
        wr_in && addr_in == 8'haa;
    endsequence

    sequence s_dir_write;
        wr_in && addr_in == 8'hac;
    endsequence

    sequence s_latch_read;
        rd_in && addr_in == 8'haa;
    endsequence

    sequence s_level_read;
        rd_in && addr_in == 8'hab;
    endsequence

    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_reset_clear;
        reset_in |=> pin_out == 8'h00 && pin_oe_out == 8'h00
            && pullup_en_out == 8'h00 && rdata_out == 8'h00;
    endproperty

    property p_latch_write;
        disable iff (reset_in) s_latch_write |=> pin_out == $past(wdata_in);
    endproperty

    property p_dir_write;
        disable iff (reset_in) s_dir_write |=> pin_oe_out == $past(wdata_in);
    endproperty

    property p_level_read;
        disable iff (reset_in) s_level_read |=> rdata_out == $past(pin_in);
    endproperty

    property p_latch_read;
        disable iff (reset_in) s_latch_read |=> rdata_out == $past(pin_out);
    endproperty

    property p_pullup_off;
        disable iff (reset_in) (~pin_oe_out & ~pin_out & pullup_en_out) == 8'h00;
    endproperty

    property p_pullup_on;
        disable iff (reset_in) (~pin_oe_out & pin_out & ~pullup_en_out) == 8'h00;
    endproperty

    property p_read_idle;
        disable iff (reset_in) !rd_in |=> rdata_out == 8'h00;
    endproperty

    property p_pin_hold;
        disable iff (reset_in) !(wr_in && (addr_in == 8'haa || addr_in == 8'hac))
            |=> $stable(pin_out) && $stable(pin_oe_out) && $stable(pullup_en_out);
    endproperty

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_reset_clear: assert property (p_reset_clear)
        else $error("outputs not cleared by reset");
    a_latch_write: assert property (p_latch_write)
        else $error("latch write not driven on pins");
    a_dir_write: assert property (p_dir_write)
        else $error("direction write not seen on output enables");
    a_level_read: assert property (p_level_read)
        else $error("pin level read mismatch");
    a_latch_read: assert property (p_latch_read)
        else $error("latch read mismatch");
    a_pullup_off: assert property (p_pullup_off)
        else $error("pull-up on for input with latch bit 0");
    a_pullup_on: assert property (p_pullup_on)
        else $error("pull-up off for input with latch bit 1");
    a_read_idle: assert property (p_read_idle)
        else $error("read data not zero outside read cycle");
    a_pin_hold: assert property (p_pin_hold)
        else $error("pins changed without a write");

endmodule

bind port_a_data port_a_chk u_chk (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe_out(pin_oe_out),
    .pullup_en_out(pullup_en_out)
);

// ---- tb/pin_board.sv ----
`timescale 1ns/1ps
module pin_board(input wire [7:0] pin_out,pin_oe_out,pullup_en_out,output wire [7:0] pin_in);
assign pin_in=pin_oe_out&pin_out|~pin_oe_out&(8'h0a|8'hf0&pullup_en_out);
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
reg sys_clk_in=0,reset_in=1,wr_in=0,rd_in=0;
reg [7:0] addr_in=8'h00,wdata_in=8'h00;
wire [7:0] rdata_out,pin_in,pin_out,pin_oe_out,pullup_en_out;
int n_errors=0,tests_run=0;
port_a_data dut(.sys_clk_in(sys_clk_in),.reset_in(reset_in),.addr_in(addr_in),
.wdata_in(wdata_in),.wr_in(wr_in),.rd_in(rd_in),.rdata_out(rdata_out),.pin_in(pin_in),
.pin_out(pin_out),.pin_oe_out(pin_oe_out),.pullup_en_out(pullup_en_out));
pin_board brd(.pin_out,.pin_oe_out,.pullup_en_out,.pin_in);
initial forever #2 sys_clk_in=~sys_clk_in;
task cmp(input [8*10-1:0] n,input [7:0] e,s);
tests_run+=1;
if (s!==e) begin n_errors+=1; $display("Error %0s exp %h got %h",n,e,s); end
endtask
task acc(input w,input [7:0] a,d);
@(posedge sys_clk_in) {wr_in,rd_in,addr_in,wdata_in}<={w,!w,a,d};
@(posedge sys_clk_in) {wr_in,rd_in}<=2'b00;
#1;
endtask
task rd(input [7:0] a,e);
acc(0,a,8'h00);
cmp("rd",e,rdata_out);
endtask
task end_sim;
$display("err %0d run %0d",n_errors,tests_run);
if (n_errors==0&&tests_run>0) $display("RESULT: PASS");
else $display("RESULT: FAIL");
$finish;
endtask
initial begin
repeat(8) @(posedge sys_clk_in);
reset_in<=0;
#1 cmp("pins_rst",8'h00,pin_out|pin_oe_out|pullup_en_out);
acc(1,8'haa,8'ha5);
rd(8'haa,8'ha5);
@(posedge sys_clk_in) #1 cmp("rd_idle",8'h00,rdata_out);
cmp("pin_out",8'ha5,pin_out);
acc(1,8'hac,8'h3c);
cmp("oe",8'h3c,pin_oe_out);
cmp("pu",8'h81,pullup_en_out);
rd(8'hab,8'ha6);
rd(8'hac,8'h3c);
acc(1,8'hab,8'hff);
rd(8'hab,8'ha6);
rd(8'haa,8'ha5);
rd(8'had,8'h00);
acc(1,8'haa,8'h5a);
cmp("pu2",8'h42,pullup_en_out);
rd(8'hab,8'h5a);
@(posedge sys_clk_in) reset_in<=1;
repeat(2) @(posedge sys_clk_in);
reset_in<=0;
#1 cmp("pins_rst2",8'h00,pin_out|pin_oe_out|pullup_en_out);
rd(8'haa,8'h00);
rd(8'hab,8'h0a);
end_sim;
end
endmodule
